// >>> rtl/mode_ctrl.sv
// mode sense register, system control register and operating mode decode
//
// Operation
// - mode sense register is eight bits, read only, bit seven reads one.
// - mode sense bits six to three always read zero.
// - low three sense bits mirror the mode pins; writes ignored.
// - pins latched on sense read; power-on reset clears, manual reset keeps.
// - system control bits six and two read zero, read only.
// - irq mode field: 00 mode 0 default, 10 mode 2; 01/11 forbidden.
// - nmi edge bit: zero falling edge default, one rising edge.
// - ram enable bit resets to one; standby does not reinitialise it.
// - mode 1 eight-bit bus, b/c address, d data, 16-bit adds e.
// - mode 2 normal, rom on, b/c inputs until direction bit set.
// - modes 2 and 3 limit usable rom to 56 kbytes.
// - modes 3 and 7 rom on, external blocked, all ports general.
// - mode 4 16 Mbyte, rom off, a-c address, d/e data, 16-bit; code drops to eight-bit with e off when all areas are eight-bit.
// - modes 5 and 6 start eight-bit, go 16-bit when any area is.
// - mode 6 16 Mbyte, rom on, a-c inputs until direction bit set.
// - expanded modes use port f pins 6..3 as control; single-chip general.
// - pins decode binary; small variant valid 1,4,5; 1-3 normal, 4-7 advanced.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module mode_ctrl
  import mode_ctrl_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  // clock and resets
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       manual_rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // strap pins
  input  wire logic [2:0] mode_pin,
  // bus controller status
  input  wire logic       any_area_16,
  input  wire logic       all_area_8,
  input  wire logic [2:0] port_ddr_addr,
  // nmi input and standby
  input  wire logic       nmi_in,
  input  wire logic       sw_standby,
  // decoded outputs
  output logic      [1:0] irq_ctrl_mode,
  output logic            irq_use_priority,
  output logic            nmi_req,
  output logic            ram_on,
  output mode_cfg_t       mode_cfg
);

  // ---------------------------------------------------------------------------
  // pin and nmi synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic       nmi_s1_ff, nmi_s2_ff, nmi_s3_ff;
  logic       nmi_lvl_ff;
  logic [2:0] pin_lvl_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
      nmi_s1_ff <= 1'b1;
      nmi_s2_ff <= 1'b1;
      nmi_s3_ff <= 1'b1;
    end else begin
      pin_s1_ff <= mode_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      nmi_s1_ff <= nmi_in;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
    end
  end

  // a level is taken once the second and third stages agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_lvl_ff <= 3'h0;
      nmi_lvl_ff <= 1'b1;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_ff[i] == pin_s3_ff[i]) pin_lvl_ff[i] <= pin_s3_ff[i];
      end
      if (nmi_s2_ff == nmi_s3_ff) nmi_lvl_ff <= nmi_s3_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // mode sense latch
  // ---------------------------------------------------------------------------
  logic       sense_rd;
  logic [2:0] sense_ff;
  logic [2:0] mode_latch_ff;
  logic       mode_known_ff;
  logic [1:0] sync_fill_ff;

  assign sense_rd = reg_rd && (reg_addr == MODE_PIN_SENSE_OFS);

  // arst_n is power-on reset; manual_rst does not touch the latch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sense_ff <= SENSE_RESET;
    end else if (sense_rd) begin
      sense_ff <= pin_lvl_ff;
    end
  end

  // the pin pipeline still holds reset zeros for the first edges after release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_fill_ff <= 2'h0;
    end else if (sync_fill_ff != SYNC_FILL_CYCLES) begin
      sync_fill_ff <= sync_fill_ff + 2'h1;
    end
  end

  // operating mode is taken from the straps once after reset release
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_latch_ff <= 3'h0;
      mode_known_ff <= 1'b0;
    end else if (!mode_known_ff && sync_fill_ff == SYNC_FILL_CYCLES
                 && pin_s2_ff == pin_s3_ff) begin
      mode_latch_ff <= pin_s3_ff;
      mode_known_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // system control register
  // ---------------------------------------------------------------------------
  logic [7:0] sysctl_ff;
  logic       sysctl_wr;

  assign sysctl_wr = reg_wr && (reg_addr == SYSTEM_CONTROL_OFS);

  // standby does not reset the register; only arst_n and manual_rst do
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysctl_ff <= SYSTEM_CONTROL_RESET;
    end else if (manual_rst) begin
      sysctl_ff <= SYSTEM_CONTROL_RESET;
    end else if (sysctl_wr) begin
      sysctl_ff <= reg_wdata & SYSTEM_CONTROL_WRITE_MASK;
    end
  end

  assign irq_ctrl_mode    = sysctl_ff[IRQ_MODE_HI_BIT:IRQ_MODE_LO_BIT];
  assign irq_use_priority = (irq_ctrl_mode == IRQ_MODE_2);
  assign ram_on           = sysctl_ff[RAM_ON_BIT];

  // ---------------------------------------------------------------------------
  // nmi edge detect
  // ---------------------------------------------------------------------------
  logic nmi_prev_ff;
  logic nmi_req_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_prev_ff <= 1'b1;
      nmi_req_ff  <= 1'b0;
    end else begin
      nmi_prev_ff <= nmi_lvl_ff;
      if (sysctl_ff[NMI_EDGE_BIT])
        nmi_req_ff <= nmi_lvl_ff && !nmi_prev_ff;
      else
        nmi_req_ff <= !nmi_lvl_ff && nmi_prev_ff;
    end
  end

  assign nmi_req = nmi_req_ff;

  // ---------------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------------
  logic [7:0] rdata_ff;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 8'h00;
    end else if (sense_rd) begin
      rdata_ff <= SENSE_FIXED | {5'h00, pin_lvl_ff};
    end else if (reg_rd && reg_addr == SYSTEM_CONTROL_OFS) begin
      rdata_ff <= sysctl_ff;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

  // ---------------------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------------------
  mode_cfg_t cfg_c;
  mcu_mode_t mode_c;

  assign mode_c = mcu_mode_t'(mode_latch_ff);

  always_comb begin
    cfg_c            = '0;
    cfg_c.advanced   = mode_latch_ff[2];
    cfg_c.mode_valid = mode_known_ff;
    case (mode_c)
      MODE_1: begin
        cfg_c.expanded    = 1'b1;
        cfg_c.bus16       = any_area_16;
        cfg_c.addr_ports  = 3'b011;
        cfg_c.port_d_data = 1'b1;
        cfg_c.port_e_data = any_area_16;
      end
      MODE_2: begin
        cfg_c.expanded    = 1'b1;
        cfg_c.rom_on      = 1'b1;
        cfg_c.rom_kbytes  = ROM_KB_NORMAL;
        cfg_c.bus16       = any_area_16;
        cfg_c.addr_ports  = {1'b0, port_ddr_addr[1:0]};
        cfg_c.port_d_data = 1'b1;
        cfg_c.port_e_data = any_area_16;
      end
      MODE_3: begin
        cfg_c.rom_on      = 1'b1;
        cfg_c.rom_kbytes  = ROM_KB_NORMAL;
        cfg_c.ext_blocked = 1'b1;
      end
      MODE_4: begin
        cfg_c.expanded    = 1'b1;
        cfg_c.bus16       = !all_area_8;
        cfg_c.addr_ports  = 3'b111;
        cfg_c.port_d_data = 1'b1;
        cfg_c.port_e_data = !all_area_8;
      end
      MODE_5: begin
        cfg_c.expanded    = 1'b1;
        cfg_c.bus16       = any_area_16;
        cfg_c.addr_ports  = 3'b111;
        cfg_c.port_d_data = 1'b1;
        cfg_c.port_e_data = any_area_16;
      end
      MODE_6: begin
        cfg_c.expanded    = 1'b1;
        cfg_c.rom_on      = 1'b1;
        cfg_c.rom_kbytes  = ROM_KB_FULL;
        cfg_c.bus16       = any_area_16;
        cfg_c.addr_ports  = port_ddr_addr;
        cfg_c.port_d_data = 1'b1;
        cfg_c.port_e_data = any_area_16;
      end
      MODE_7: begin
        cfg_c.rom_on      = 1'b1;
        cfg_c.rom_kbytes  = ROM_KB_FULL;
        cfg_c.ext_blocked = 1'b1;
      end
      default: begin
        cfg_c.ext_blocked = 1'b1;
        cfg_c.mode_valid  = 1'b0;
      end
    endcase
    cfg_c.port_f_ctrl = cfg_c.expanded;
    if (SMALL_VARIANT && !(mode_c == MODE_1 || mode_c == MODE_4 || mode_c == MODE_5))
      cfg_c.mode_valid = 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_cfg <= '0;
    end else begin
      mode_cfg <= cfg_c;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence sense_read_s;
    reg_rd && reg_addr == MODE_PIN_SENSE_OFS;
  endsequence

  sense_fixed_bits_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sense_read_s |=> reg_rdata[7:3] == 5'h10)
    else $error("mode sense fixed bits wrong");

  sense_pin_echo_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sense_read_s |=> reg_rdata[2:0] == $past(pin_lvl_ff) && sense_ff == reg_rdata[2:0])
    else $error("mode sense read not fresh pin levels");

  sense_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !sense_rd |=> $stable(sense_ff))
    else $error("mode sense latch changed without read");

  sysctl_rsv_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sysctl_ff[SYSTEM_CONTROL_RSV6_BIT] == 1'b0 && sysctl_ff[SYSTEM_CONTROL_RSV2_BIT] == 1'b0)
    else $error("system control reserved bits set");

  irq_prio_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sysctl_wr && !manual_rst && reg_wdata[5:4] == IRQ_MODE_2 |=> irq_use_priority)
    else $error("irq mode 2 not selected");

  nmi_fall_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !sysctl_ff[NMI_EDGE_BIT] && $fell(nmi_lvl_ff) && $stable(sysctl_ff) |=> nmi_req)
    else $error("nmi falling edge missed");

  ram_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    manual_rst |=> ram_on ##0 irq_ctrl_mode == IRQ_MODE_0)
    else $error("system control not reset");

  standby_keep_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    sw_standby && !sysctl_wr && !manual_rst |=> $stable(ram_on))
    else $error("ram enable changed in standby");

  single_chip_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_known_ff && mode_latch_ff[1:0] == 2'b11 |=> mode_cfg.ext_blocked && mode_cfg.rom_on
      && mode_cfg.addr_ports == 3'h0 && !mode_cfg.port_f_ctrl)
    else $error("single-chip mode exposes external bus");

  mode4_bus_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_known_ff && mode_latch_ff == 3'b100 && !all_area_8 |=> mode_cfg.bus16)
    else $error("mode 4 not on 16-bit bus");

endmodule : mode_ctrl

// >>> rtl/mode_ctrl_pkg.sv
// package: register map, field layout, reset values and mode encodings of the mode/system block
package mode_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MODE_PIN_SENSE_OFS = 8'h3b;
  localparam logic [7:0] SYSTEM_CONTROL_OFS = 8'h39;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int SENSE_FIXED_ONE_BIT = 7;
  localparam int SENSE_RSV_HI        = 6;
  localparam int SENSE_RSV_LO        = 3;
  localparam int SENSE_MODE_HI       = 2;
  localparam int SYSTEM_CONTROL_RSV7_BIT      = 7;
  localparam int SYSTEM_CONTROL_RSV6_BIT      = 6;
  localparam int IRQ_MODE_HI_BIT     = 5;
  localparam int IRQ_MODE_LO_BIT     = 4;
  localparam int NMI_EDGE_BIT        = 3;
  localparam int SYSTEM_CONTROL_RSV2_BIT      = 2;
  localparam int SYSTEM_CONTROL_RSV1_BIT      = 1;
  localparam int RAM_ON_BIT          = 0;

  // ---------------------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_RESET      = 8'h01;
  localparam logic [7:0] SYSTEM_CONTROL_WRITE_MASK = 8'hbb;
  localparam logic [7:0] SENSE_FIXED      = 8'h80;
  localparam logic [2:0] SENSE_RESET      = 3'h0;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  // edges after reset release before the strap pipeline holds real pin levels
  localparam logic [1:0] SYNC_FILL_CYCLES = 2'h3;

  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] IRQ_MODE_0 = 2'h0;
  localparam logic [1:0] IRQ_MODE_2 = 2'h2;

  typedef enum logic [2:0] {
    MODE_0 = 3'b000,
    MODE_1 = 3'b001,
    MODE_2 = 3'b010,
    MODE_3 = 3'b011,
    MODE_4 = 3'b100,
    MODE_5 = 3'b101,
    MODE_6 = 3'b110,
    MODE_7 = 3'b111
  } mcu_mode_t;

  // on-chip rom usable size in kbytes for normal and advanced rom-enabled modes
  localparam logic [6:0] ROM_KB_NORMAL = 7'd56;
  localparam logic [6:0] ROM_KB_FULL   = 7'd64;

  // port roles after decode
  typedef struct packed {
    logic       expanded;
    logic       advanced;
    logic       rom_on;
    logic       ext_blocked;
    logic       bus16;
    logic [2:0] addr_ports;     // a, b, c: 1 = address output
    logic       port_d_data;
    logic       port_e_data;
    logic       port_f_ctrl;    // pins 6..3 as bus control / clock
    logic       mode_valid;
    logic [6:0] rom_kbytes;
  } mode_cfg_t;

endpackage : mode_ctrl_pkg

// >>> tb/strap_board.sv
// board strap model: holds the chosen levels on the three mode select pins
`timescale 1ns/1ps
module strap_board (
  // chosen strap setting
  input  wire logic [2:0] setting,
  // mode select pins
  output logic      [2:0] mode_pin
);
  // straps are tied resistors, so the pins simply follow the chosen setting
  assign mode_pin = setting;
endmodule : strap_board

// >>> tb/mode_ctrl_tb.sv
// testbench for the mode sense, system control and mode decode block
`timescale 1ns/1ps
module mode_ctrl_tb;
  import mode_ctrl_pkg::*;
  logic       core_clk, arst_n, manual_rst, reg_wr, reg_rd, any_area_16, all_area_8;
  logic       nmi_in, sw_standby, irq_use_priority, nmi_req, ram_on;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] strap, mode_pin, port_ddr_addr;
  logic [1:0] irq_ctrl_mode;
  mode_cfg_t  mode_cfg, small_cfg;
  int         fail_count, samples_checked;

  strap_board brd (.setting(strap), .mode_pin(mode_pin));
  mode_ctrl #(.SMALL_VARIANT(1'b0)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .manual_rst(manual_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_pin(mode_pin), .any_area_16(any_area_16), .all_area_8(all_area_8),
    .port_ddr_addr(port_ddr_addr), .nmi_in(nmi_in), .sw_standby(sw_standby),
    .irq_ctrl_mode(irq_ctrl_mode), .irq_use_priority(irq_use_priority), .nmi_req(nmi_req),
    .ram_on(ram_on), .mode_cfg(mode_cfg));
  // smaller variant on the same straps: only three modes are valid there
  mode_ctrl #(.SMALL_VARIANT(1'b1)) uut_small (
    .core_clk(core_clk), .arst_n(arst_n), .manual_rst(manual_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .mode_pin(mode_pin), .any_area_16(any_area_16), .all_area_8(all_area_8),
    .port_ddr_addr(port_ddr_addr), .nmi_in(nmi_in), .sw_standby(sw_standby),
    .irq_ctrl_mode(), .irq_use_priority(), .nmi_req(),
    .ram_on(), .mode_cfg(small_cfg));

  always #2 core_clk = ~core_clk;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    // hand back on a rising edge so the caller drives inputs there
    @(posedge core_clk);
  endtask : rd

  task automatic por();
    arst_n <= 1'b0;
    cyc(6);
    arst_n <= 1'b1;
    cyc(10);
  endtask : por

  // counts nmi pulses within a bounded window after an input level change
  task automatic nmi_try(input logic lvl, input logic [7:0] exp);
    int hit;
    hit = 0;
    @(posedge core_clk);
    nmi_in <= lvl;
    repeat (12) begin
      @(posedge core_clk);
      #1 if (nmi_req === 1'b1) hit++;
    end
    chk("nmi_pulses", hit[7:0], exp);
  endtask : nmi_try

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    core_clk = 0; arst_n = 0; manual_rst = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00;
    reg_wdata = 8'h00; any_area_16 = 0; all_area_8 = 0; nmi_in = 1; sw_standby = 0;
    strap = 3'h0; port_ddr_addr = 3'h0; fail_count = 0; samples_checked = 0;
    for (int m = 0; m < 8; m++) begin
      strap <= m[2:0];
      por();
      rd(MODE_PIN_SENSE_OFS, d);
      chk("sense", d, 8'h80 | m[7:0]);
      chk("valid", mode_cfg.mode_valid, m != 0);
      chk("valid_small", small_cfg.mode_valid, m == 1 || m == 4 || m == 5);
      chk("expanded", mode_cfg.expanded, m != 0 && m != 3 && m != 7);
      chk("port_d", mode_cfg.port_d_data, m != 0 && m != 3 && m != 7);
      chk("port_e_init", mode_cfg.port_e_data, m == 4);
      chk("blocked", mode_cfg.ext_blocked, m == 0 || m == 3 || m == 7);
      chk("ctrl_f", mode_cfg.port_f_ctrl, m != 0 && m != 3 && m != 7);
      chk("bus16", mode_cfg.bus16, m == 4);
      if (m != 0) begin
        chk("advanced", mode_cfg.advanced, m >= 4);
        chk("rom_on", mode_cfg.rom_on, m == 2 || m == 3 || m >= 6);
        chk("rom_kb", mode_cfg.rom_kbytes, m inside {2, 3} ? 8'h38 : (m >= 6 ? 8'h40 : 8'h00));
      end
      if (m == 1) chk("addr1", mode_cfg.addr_ports, 8'h03);
      if (m == 4 || m == 5) chk("addr45", mode_cfg.addr_ports, 8'h07);
      if (m == 2 || m == 6) begin
        chk("addr_in", mode_cfg.addr_ports, 8'h00);
        port_ddr_addr <= 3'b101;
        cyc(3);
        chk("addr_ddr", mode_cfg.addr_ports, m == 2 ? 8'h01 : 8'h05);
        port_ddr_addr <= 3'b000;
      end
      if (m == 3 || m == 7) chk("addr_sc", mode_cfg.addr_ports, 8'h00);
      any_area_16 <= 1'b1;
      cyc(3);
      if (m != 0 && m != 3 && m != 7) begin
        chk("bus16_up", mode_cfg.bus16, 8'h01);
        chk("port_e", mode_cfg.port_e_data, 8'h01);
      end
      any_area_16 <= 1'b0;
      all_area_8 <= 1'b1;
      cyc(3);
      if (m == 4) chk("bus8_down", mode_cfg.bus16, 8'h00);
      all_area_8 <= 1'b0;
    end
    // register behaviour in mode 5
    strap <= 3'h5;
    por();
    rd(SYSTEM_CONTROL_OFS, d);
    chk("sysctl_rst", d, 8'h01);
    chk("ram_on_rst", ram_on, 8'h01);
    chk("irq_rst", irq_ctrl_mode, 8'h00);
    wr(MODE_PIN_SENSE_OFS, 8'h7f);
    rd(MODE_PIN_SENSE_OFS, d);
    chk("sense_wr", d, 8'h85);
    rd(8'h3a, d);
    chk("unmapped", d, 8'h00);
    // bits six and two set, seven and one kept zero by software
    wr(SYSTEM_CONTROL_OFS, 8'h6c);
    rd(SYSTEM_CONTROL_OFS, d);
    chk("sysctl_rsv", d, 8'h28);
    chk("irq_mode2", irq_ctrl_mode, 8'h02);
    chk("irq_prio", irq_use_priority, 8'h01);
    chk("ram_off", ram_on, 8'h00);
    sw_standby <= 1'b1;
    cyc(3);
    sw_standby <= 1'b0;
    cyc(2);
    chk("standby_keep", ram_on, 8'h00);
    manual_rst <= 1'b1;
    cyc(2);
    manual_rst <= 1'b0;
    cyc(2);
    rd(SYSTEM_CONTROL_OFS, d);
    chk("sysctl_man", d, 8'h01);
    chk("irq_mode0", irq_use_priority, 8'h00);
    rd(MODE_PIN_SENSE_OFS, d);
    chk("sense_man", d, 8'h85);
    // nmi edge selection, falling then rising
    nmi_try(1'b0, 8'h01);
    nmi_try(1'b1, 8'h00);
    wr(SYSTEM_CONTROL_OFS, 8'h09);
    nmi_try(1'b0, 8'h00);
    nmi_try(1'b1, 8'h01);
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule : mode_ctrl_tb
